// >>> hw/tcp_map.svh
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
// byte offsets
`define TCP_OFS_CAP_LO  8'h22
`define TCP_OFS_CAP_HI  8'h23
`define TCP_OFS_CMPB_LO 8'h24
`define TCP_OFS_CMPB_HI 8'h25
`define TCP_OFS_CMPA_LO 8'h26
`define TCP_OFS_CMPA_HI 8'h27
`define TCP_OFS_CNT_LO  8'h28
`define TCP_OFS_CNT_HI  8'h29
`define TCP_OFS_FLAGS   8'h2a
`define TCP_OFS_MASK    8'h2b
`define TCP_OFS_FORCE   8'h2c
`define TCP_OFS_GCTL    8'h2f
`define TCP_OFS_CSRC    8'h30
// flag and mask bit positions
`define TCP_BIT_CAP     5
`define TCP_BIT_MB      2
`define TCP_BIT_MA      1
`define TCP_BIT_WRAP    0
`define TCP_IRQ_BITS    8'h27
// force strobes
`define TCP_BIT_FA      7
`define TCP_BIT_FB      6
// global control
`define TCP_BIT_TSM     7
`define TCP_BIT_MAP     1
`define TCP_BIT_PSR     0
// capture source control
`define TCP_BIT_SRC_AC  0
`define TCP_BIT_SRC_RISE 1
// values
`define TCP_RST8        8'h00
`define TCP_RST16       16'h0000
`define TCP_ONE16       16'h0001
`define TCP_MAX16       16'hffff
`define TCP_PRE_W       10
`define TCP_PRE_ONE     10'h001
`define TCP_PRE_ZERO    10'h000
`endif

// >>> hw/tcp_pkg.sv
`include "tcp_map.svh"
package tcp_pkg;
    typedef enum logic [0:0] {
        TCP_IDLE   = 1'b0,
        TCP_ANSWER = 1'b1
    } tcp_bus_t;

    typedef struct packed {
        tcp_bus_t               bus;
        logic [7:0]             rdata;
        logic [7:0]             temp;
        logic [15:0]            capture;
        logic [15:0]            count;
        logic [15:0]            cmp_a;
        logic [15:0]            cmp_b;
        logic [7:0]             flags;
        logic [7:0]             mask;
        logic                   sync_hold_mode;
        logic                   pin_map_select;
        logic                   prescaler_clear;
        logic                   src_ac;
        logic                   src_rise;
        logic                   suppress;
        logic [`TCP_PRE_W-1:0]  pre_cnt;
        logic                   cap_s1;
        logic                   cap_s2;
        logic                   ac_s1;
        logic                   ac_s2;
        logic                   ext_s1;
        logic                   ext_s2;
        logic                   src_d;
        logic                   wave_a;
        logic                   wave_b;
    } tcp_state_t;
endpackage : tcp_pkg

// >>> hw/tcp_timer.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_timer #(
    parameter logic [`TCP_PRE_W-1:0] PRESCALE_DIV = `TCP_PRE_ONE
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // avalon-mm slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [7:0]  i_avs_writedata,
    output logic      [7:0]  o_avs_readdata,
    output logic             o_avs_waitrequest,
    // waveform mode from the counter mode logic
    input  wire logic        i_capture_is_top,
    input  wire logic        i_clear_on_match_a,
    input  wire logic        i_pwm_mode,
    // core interrupt side: cap, match b, match a, wrap
    input  wire logic [3:0]  i_vector_ack,
    output logic      [3:0]  o_irq,
    // pins
    input  wire logic        i_capture_pin_pb2,
    input  wire logic        i_capture_pin_pa4,
    input  wire logic        i_comparator_out,
    input  wire logic        i_ext_count_clock_pa0,
    input  wire logic        i_ext_count_clock_pb3,
    output logic             o_ext_count_clock,
    output logic             o_wave_out_a_pb1,
    output logic             o_wave_out_a_pa3,
    output logic             o_wave_out_b_pa1,
    output logic             o_wave_out_b_pa5,
    output logic             o_pin_map_select,
    output logic      [15:0] o_count_value
);
    import tcp_pkg::*;

    localparam int IRQ_POS [4] = '{`TCP_BIT_WRAP, `TCP_BIT_MA, `TCP_BIT_MB, `TCP_BIT_CAP};

    tcp_state_t s_r;
    tcp_state_t s_nxt;

    logic        req;
    logic        acc;
    logic        wr;
    logic        rdx;
    logic        presc_rst;
    logic        tick;
    logic        src_now;
    logic        cap_edge;
    logic [15:0] top_val;
    logic [7:0]  flag_set;
    logic [7:0]  flag_clr;
    logic [7:0]  rd_mux;

    always_comb begin
        s_nxt = s_r;
        req = i_avs_read | i_avs_write;
        acc = s_r.bus == TCP_ANSWER;
        wr = i_avs_write & acc;
        rdx = i_avs_read & acc;
        flag_set = `TCP_RST8;
        flag_clr = `TCP_RST8;
        tick = 1'b0;

        // pins are asynchronous; two stages before any use
        s_nxt.cap_s1 = s_r.pin_map_select ? i_capture_pin_pa4 : i_capture_pin_pb2;
        s_nxt.cap_s2 = s_r.cap_s1;
        s_nxt.ac_s1 = i_comparator_out;
        s_nxt.ac_s2 = s_r.ac_s1;
        s_nxt.ext_s1 = s_r.pin_map_select ? i_ext_count_clock_pb3 : i_ext_count_clock_pa0;
        s_nxt.ext_s2 = s_r.ext_s1;
        src_now = s_r.src_ac ? s_r.ac_s2 : s_r.cap_s2;
        s_nxt.src_d = src_now;
        cap_edge = s_r.src_rise ? (src_now & ~s_r.src_d) : (~src_now & s_r.src_d);

        // capture bytes readable
        // read mux, sampled on the first cycle of a request
        case (i_avs_address)
            `TCP_OFS_CAP_LO:  rd_mux = s_r.capture[7:0];
            `TCP_OFS_CAP_HI:  rd_mux = s_r.temp;
            `TCP_OFS_CMPB_LO: rd_mux = s_r.cmp_b[7:0];
            `TCP_OFS_CMPB_HI: rd_mux = s_r.cmp_b[15:8];
            `TCP_OFS_CMPA_LO: rd_mux = s_r.cmp_a[7:0];
            `TCP_OFS_CMPA_HI: rd_mux = s_r.cmp_a[15:8];
            `TCP_OFS_CNT_LO:  rd_mux = s_r.count[7:0];
            `TCP_OFS_CNT_HI:  rd_mux = s_r.temp;
            `TCP_OFS_FLAGS:   rd_mux = s_r.flags;
            `TCP_OFS_MASK:    rd_mux = s_r.mask;
            `TCP_OFS_GCTL: begin
                rd_mux = `TCP_RST8;
                rd_mux[`TCP_BIT_TSM] = s_r.sync_hold_mode;
                rd_mux[`TCP_BIT_MAP] = s_r.pin_map_select;
                rd_mux[`TCP_BIT_PSR] = s_r.prescaler_clear;
            end
            `TCP_OFS_CSRC: begin
                rd_mux = `TCP_RST8;
                rd_mux[`TCP_BIT_SRC_AC] = s_r.src_ac;
                rd_mux[`TCP_BIT_SRC_RISE] = s_r.src_rise;
            end
            // force strobes and unmapped space read zero
            default:          rd_mux = `TCP_RST8;
        endcase

        // one wait cycle per access; effects land on the answer edge
        case (s_r.bus)
            TCP_IDLE: begin
                if (req) begin
                    s_nxt.bus = TCP_ANSWER;
                    s_nxt.rdata = rd_mux;
                end
            end
            TCP_ANSWER: begin
                s_nxt.bus = TCP_IDLE;
            end
            default: begin
                s_nxt.bus = TCP_IDLE;
            end
        endcase

        presc_rst = s_r.prescaler_clear | (wr & (i_avs_address == `TCP_OFS_GCTL)
                    & i_avs_writedata[`TCP_BIT_PSR]);
        if (presc_rst) begin
            s_nxt.pre_cnt = `TCP_PRE_ZERO;
        end else if (s_r.pre_cnt >= PRESCALE_DIV - `TCP_PRE_ONE) begin
            s_nxt.pre_cnt = `TCP_PRE_ZERO;
            tick = 1'b1;
        end else begin
            s_nxt.pre_cnt = s_r.pre_cnt + `TCP_PRE_ONE;
        end

        if (i_capture_is_top) begin
            top_val = s_r.capture;
        end else if (i_clear_on_match_a) begin
            top_val = s_r.cmp_a;
        end else begin
            top_val = `TCP_MAX16;
        end

        if (tick) begin
            s_nxt.count = (s_r.count == top_val) ? `TCP_RST16 : s_r.count + `TCP_ONE16;
            s_nxt.suppress = 1'b0;
            if (s_r.count == s_r.cmp_a && !s_r.suppress) begin
                flag_set[`TCP_BIT_MA] = 1'b1;
                s_nxt.wave_a = ~s_r.wave_a;
            end
            if (s_r.count == s_r.cmp_b && !s_r.suppress) begin
                flag_set[`TCP_BIT_MB] = 1'b1;
                s_nxt.wave_b = ~s_r.wave_b;
            end
            // wrap on overflow; pwm with capture top wraps at top
            if (s_r.count == `TCP_MAX16
                || (i_pwm_mode && i_capture_is_top && s_r.count == top_val)) begin
                flag_set[`TCP_BIT_WRAP] = 1'b1;
            end
            if (i_capture_is_top && s_r.count == top_val) begin
                flag_set[`TCP_BIT_CAP] = 1'b1;
            end
        end

        if (rdx) begin
            case (i_avs_address)
                `TCP_OFS_CAP_LO: s_nxt.temp = s_r.capture[15:8];
                `TCP_OFS_CNT_LO: s_nxt.temp = s_r.count[15:8];
                default:         s_nxt.temp = s_r.temp;
            endcase
        end

        if (wr) begin
            case (i_avs_address)
                `TCP_OFS_CAP_HI, `TCP_OFS_CMPB_HI, `TCP_OFS_CMPA_HI, `TCP_OFS_CNT_HI: begin
                    s_nxt.temp = i_avs_writedata;
                end
                `TCP_OFS_CAP_LO:  s_nxt.capture = {s_r.temp, i_avs_writedata};
                `TCP_OFS_CMPB_LO: s_nxt.cmp_b = {s_r.temp, i_avs_writedata};
                `TCP_OFS_CMPA_LO: s_nxt.cmp_a = {s_r.temp, i_avs_writedata};
                `TCP_OFS_CNT_LO: begin
                    s_nxt.count = {s_r.temp, i_avs_writedata};
                    s_nxt.suppress = 1'b1;
                end
                `TCP_OFS_FLAGS:   flag_clr = i_avs_writedata & `TCP_IRQ_BITS;
                `TCP_OFS_MASK:    s_nxt.mask = i_avs_writedata & `TCP_IRQ_BITS;
                // force acts on outputs only, outside pwm
                `TCP_OFS_FORCE: begin
                    if (!i_pwm_mode) begin
                        s_nxt.wave_a = s_nxt.wave_a ^ i_avs_writedata[`TCP_BIT_FA];
                        s_nxt.wave_b = s_nxt.wave_b ^ i_avs_writedata[`TCP_BIT_FB];
                    end
                end
                `TCP_OFS_GCTL: begin
                    s_nxt.sync_hold_mode = i_avs_writedata[`TCP_BIT_TSM];
                    s_nxt.pin_map_select = i_avs_writedata[`TCP_BIT_MAP];
                    s_nxt.prescaler_clear = i_avs_writedata[`TCP_BIT_PSR]
                                & i_avs_writedata[`TCP_BIT_TSM];
                end
                `TCP_OFS_CSRC: begin
                    s_nxt.src_ac = i_avs_writedata[`TCP_BIT_SRC_AC];
                    s_nxt.src_rise = i_avs_writedata[`TCP_BIT_SRC_RISE];
                end
                default: begin
                    s_nxt.temp = s_nxt.temp;
                end
            endcase
        end

        // capture copies counter; event beats a same-cycle bus write
        if (cap_edge && !i_capture_is_top) begin
            s_nxt.capture = s_r.count;
            flag_set[`TCP_BIT_CAP] = 1'b1;
        end

        flag_clr[`TCP_BIT_WRAP] = flag_clr[`TCP_BIT_WRAP] | i_vector_ack[0];
        flag_clr[`TCP_BIT_MA] = flag_clr[`TCP_BIT_MA] | i_vector_ack[1];
        flag_clr[`TCP_BIT_MB] = flag_clr[`TCP_BIT_MB] | i_vector_ack[2];
        flag_clr[`TCP_BIT_CAP] = flag_clr[`TCP_BIT_CAP] | i_vector_ack[3];
        // set wins over clear so no event is lost
        s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_avs_readdata = s_r.rdata;
    assign o_avs_waitrequest = req & (s_r.bus != TCP_ANSWER);

    for (genvar g = 0; g < 4; g++) begin : g_irq
        assign o_irq[g] = s_r.flags[IRQ_POS[g]] & s_r.mask[IRQ_POS[g]];
    end

    // pin routing; unselected pins stay low
    assign o_pin_map_select = s_r.pin_map_select;
    assign o_ext_count_clock = s_r.ext_s2;
    assign o_wave_out_a_pb1 = ~s_r.pin_map_select & s_r.wave_a;
    assign o_wave_out_a_pa3 = s_r.pin_map_select & s_r.wave_a;
    assign o_wave_out_b_pa1 = ~s_r.pin_map_select & s_r.wave_b;
    assign o_wave_out_b_pa5 = s_r.pin_map_select & s_r.wave_b;
    assign o_count_value = s_r.count;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    cap_lo_read_a: assert property (
        (i_avs_read && i_avs_address == `TCP_OFS_CAP_LO && !o_avs_waitrequest)
        |-> o_avs_readdata == $past(s_r.capture[7:0]))
        else $error("capture low read mismatch");

    cap_hi_latch_a: assert property (
        (rdx && i_avs_address == `TCP_OFS_CAP_LO) |=> s_r.temp == $past(s_r.capture[15:8]))
        else $error("capture high not latched");

    cap_hi_read_a: assert property (
        (rdx && i_avs_address == `TCP_OFS_CAP_HI) |-> o_avs_readdata == $past(s_r.temp))
        else $error("capture high read not from latch");

    cap_write_a: assert property (
        (wr && i_avs_address == `TCP_OFS_CAP_LO && !cap_edge)
        |=> s_r.capture == $past({s_r.temp, i_avs_writedata}))
        else $error("capture write not atomic");

    cap_copy_a: assert property (
        (cap_edge && !i_capture_is_top) |=> s_r.capture == $past(s_r.count)
        && s_r.flags[`TCP_BIT_CAP])
        else $error("capture event lost");

    flag_w1c_a: assert property (
        (wr && i_avs_address == `TCP_OFS_FLAGS && i_avs_writedata[`TCP_BIT_MA]
        && !flag_set[`TCP_BIT_MA]) |=> !s_r.flags[`TCP_BIT_MA])
        else $error("match a flag not cleared");

    match_a_set_a: assert property (
        (tick && s_r.count == s_r.cmp_a && !s_r.suppress) |=> s_r.flags[`TCP_BIT_MA])
        else $error("match a flag missed");

    match_b_set_a: assert property (
        (tick && s_r.count == s_r.cmp_b && !s_r.suppress) |=> s_r.flags[`TCP_BIT_MB])
        else $error("match b flag missed");

    match_block_a: assert property (
        (wr && i_avs_address == `TCP_OFS_CNT_LO) ##1 tick
        |-> !flag_set[`TCP_BIT_MA] && !flag_set[`TCP_BIT_MB])
        else $error("match after counter write");

    cap_w1c_a: assert property (
        (wr && i_avs_address == `TCP_OFS_FLAGS && i_avs_writedata[`TCP_BIT_CAP]
        && !flag_set[`TCP_BIT_CAP]) |=> !s_r.flags[`TCP_BIT_CAP])
        else $error("capture flag not cleared");

    vector_clear_a: assert property (
        (i_vector_ack[0] && !flag_set[`TCP_BIT_WRAP]) |=> !s_r.flags[`TCP_BIT_WRAP])
        else $error("wrap flag not cleared by vector");

    wrap_set_a: assert property (
        (tick && s_r.count == `TCP_MAX16) |=> s_r.flags[`TCP_BIT_WRAP])
        else $error("wrap flag missed");

    mask_write_a: assert property (
        (wr && i_avs_address == `TCP_OFS_MASK)
        |=> s_r.mask == ($past(i_avs_writedata) & `TCP_IRQ_BITS))
        else $error("mask write lost");

    prescaler_rst_a: assert property (
        presc_rst |=> s_r.pre_cnt == `TCP_PRE_ZERO)
        else $error("prescaler not cleared");

    hold_no_tick_a: assert property (
        s_r.prescaler_clear |-> !tick)
        else $error("tick while prescaler held");

    force_read_zero_a: assert property (
        (rdx && i_avs_address == `TCP_OFS_FORCE) |-> o_avs_readdata == `TCP_RST8)
        else $error("force strobe read not zero");

    force_no_flag_a: assert property (
        (wr && i_avs_address == `TCP_OFS_FORCE && !tick) |=> !$rose(s_r.flags[`TCP_BIT_MB])
        && !$rose(s_r.flags[`TCP_BIT_MA]))
        else $error("force set a match flag");

    sync_hold_a: assert property (
        (s_r.sync_hold_mode && s_r.prescaler_clear && !wr) |=> s_r.prescaler_clear && s_r.count == $past(s_r.count))
        else $error("counter moved in sync hold");

    sync_release_a: assert property (
        (wr && i_avs_address == `TCP_OFS_GCTL && !i_avs_writedata[`TCP_BIT_TSM])
        |=> !s_r.prescaler_clear && !s_r.sync_hold_mode)
        else $error("prescaler clear not dropped");

    irq_gate_a: assert property (
        $rose(s_r.flags[`TCP_BIT_CAP]) && s_r.mask[`TCP_BIT_CAP] |-> o_irq[3] ##1
        (o_irq[3] == (s_r.flags[`TCP_BIT_CAP] && s_r.mask[`TCP_BIT_CAP])))
        else $error("capture request wrong");

    cap_event_c: cover property (cap_edge && !i_capture_is_top);
    wrap_c: cover property (flag_set[`TCP_BIT_WRAP]);
    force_c: cover property (wr && i_avs_address == `TCP_OFS_FORCE);
    sync_c: cover property (s_r.sync_hold_mode && s_r.prescaler_clear ##1 !s_r.sync_hold_mode);
    match_block_c: cover property ((wr && i_avs_address == `TCP_OFS_CNT_LO) ##1 tick);

endmodule : tcp_timer
`default_nettype wire

// >>> tb/tcp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcp_core_model (
    // clock
    input  wire logic       i_sys_clk,
    // avalon-mm master side
    output logic      [7:0] o_address,
    output logic            o_read,
    output logic            o_write,
    output logic      [7:0] o_writedata,
    input  wire logic [7:0] i_readdata,
    input  wire logic       i_waitrequest,
    // vector executed pulses
    output logic      [3:0] o_vector_ack
);
    initial begin
        o_address    = 8'h00;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_writedata  = 8'h00;
        o_vector_ack = 4'h0;
    end

    // request held until waitrequest is sampled low
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_address   <= a;
        o_writedata <= d;
        o_write     <= 1'b1;
        @(posedge i_sys_clk);
        while (i_waitrequest !== 1'b0) @(posedge i_sys_clk);
        o_write     <= 1'b0;
        // stale data would hide a late write
        o_writedata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge i_sys_clk);
        o_address <= a;
        o_read    <= 1'b1;
        @(posedge i_sys_clk);
        while (i_waitrequest !== 1'b0) @(posedge i_sys_clk);
        q = i_readdata;
        o_read    <= 1'b0;
    endtask : rd

    // one-cycle vector executed pulse
    task automatic ack(input logic [3:0] v);
        @(posedge i_sys_clk);
        o_vector_ack <= v;
        @(posedge i_sys_clk);
        o_vector_ack <= 4'h0;
    endtask : ack
endmodule : tcp_core_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tb_top;
    import tcp_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic [7:0]  addr, wdata, rdata, q;
    logic        rd_s, wr_s, wait_s, map_s;
    logic [3:0]  ack_s, irq_s;
    logic [2:0]  cap_drv   = 3'b000;
    logic [15:0] cnt_s, cv, q16;
    logic [15:0] lfsr      = 16'h7e95;
    logic [1:0]  ext_drv   = 2'b00;
    logic        pwm_s     = 1'b0;
    logic        ext_s, wa_pb1, wa_pa3, wb_pa1, wb_pa5;
    logic [1:0]  wv;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc        = 0;
    int          m_flags;

    always #20 i_sys_clk = ~i_sys_clk;

    tcp_core_model core_u (.i_sys_clk(i_sys_clk), .o_address(addr), .o_read(rd_s),
        .o_write(wr_s), .o_writedata(wdata), .i_readdata(rdata),
        .i_waitrequest(wait_s), .o_vector_ack(ack_s));

    tcp_timer dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_avs_address(addr),
        .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_s),
        .i_capture_is_top(1'b0), .i_clear_on_match_a(1'b0), .i_pwm_mode(pwm_s),
        .i_vector_ack(ack_s), .o_irq(irq_s), .i_capture_pin_pb2(cap_drv[0]),
        .i_capture_pin_pa4(cap_drv[1]), .i_comparator_out(cap_drv[2]),
        .i_ext_count_clock_pa0(ext_drv[0]), .i_ext_count_clock_pb3(ext_drv[1]),
        .o_ext_count_clock(ext_s), .o_wave_out_a_pb1(wa_pb1), .o_wave_out_a_pa3(wa_pa3),
        .o_wave_out_b_pa1(wb_pa1), .o_wave_out_b_pa5(wb_pa5), .o_pin_map_select(map_s),
        .o_count_value(cnt_s));

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // high byte through the latch first, low byte commits
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        core_u.wr(lo + 8'h01, v[15:8]);
        core_u.wr(lo, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        logic [7:0] l;
        logic [7:0] h;
        core_u.rd(lo, l);
        core_u.rd(lo + 8'h01, h);
        v = {h, l};
    endtask : rd16

    task automatic chk_flags(input string nm);
        core_u.rd(`TCP_OFS_FLAGS, q);
        chk(nm, {8'h00, q}, m_flags[15:0]);
    endtask : chk_flags

    task automatic clr_flags(input logic [7:0] w);
        core_u.wr(`TCP_OFS_FLAGS, w);
        m_flags = m_flags & ~int'(w);
    endtask : clr_flags

    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        core_u.rd(`TCP_OFS_CAP_LO, q);
        chk("cap_lo reset", {8'h00, q}, 16'h0000);
        core_u.rd(`TCP_OFS_CAP_HI, q);
        chk("cap_hi reset", {8'h00, q}, 16'h0000);
        core_u.rd(`TCP_OFS_MASK, q);
        chk("mask reset", {8'h00, q}, 16'h0000);
        core_u.rd(`TCP_OFS_GCTL, q);
        chk("gctl reset", {8'h00, q}, 16'h0000);
        lfsr = lfsr_next(lfsr);
        wr16(`TCP_OFS_CAP_LO, lfsr);
        rd16(`TCP_OFS_CAP_LO, q16);
        chk("cap rw", q16, lfsr);
        $display("test reset done");
        core_u.wr(`TCP_OFS_GCTL, 8'h81);
        core_u.rd(`TCP_OFS_GCTL, q);
        chk("gctl hold", {8'h00, q}, 16'h0081);
        wr16(`TCP_OFS_CNT_LO, 16'h0100);
        repeat (20) @(posedge i_sys_clk);
        rd16(`TCP_OFS_CNT_LO, q16);
        chk("count halted", q16, 16'h0100);
        chk("count port", cnt_s, 16'h0100);
        m_flags = 8'h27;
        clr_flags(8'h27);
        chk_flags("flags cleared");
        lfsr = lfsr_next(lfsr);
        core_u.wr(`TCP_OFS_MASK, lfsr[7:0] & 8'h27);
        core_u.rd(`TCP_OFS_MASK, q);
        chk("mask rw", {8'h00, q}, {8'h00, lfsr[7:0] & 8'h27});
        core_u.wr(`TCP_OFS_MASK, 8'h27);
        $display("test hold done");
        // wrap and both matches within one run
        wr16(`TCP_OFS_CMPA_LO, 16'h0012);
        wr16(`TCP_OFS_CNT_LO, 16'hfff0);
        core_u.wr(`TCP_OFS_GCTL, 8'h00);
        core_u.rd(`TCP_OFS_GCTL, q);
        chk("gctl resume", {8'h00, q}, 16'h0000);
        repeat (60) @(posedge i_sys_clk);
        core_u.wr(`TCP_OFS_GCTL, 8'h81);
        m_flags = 8'h07;
        chk_flags("flags wrap match");
        chk("irq", {12'h000, irq_s}, 16'h0007);
        core_u.ack(4'b0001);
        m_flags = m_flags & ~1;
        chk_flags("flags vector");
        clr_flags(8'h02);
        chk_flags("flags w1c");
        clr_flags(8'h00);
        chk_flags("flags w0");
        clr_flags(8'h04);
        chk_flags("flags clear b");
        $display("test flags done");
        core_u.wr(`TCP_OFS_GCTL, 8'h01);
        core_u.rd(`TCP_OFS_GCTL, q);
        chk("psr self clear", {8'h00, q}, 16'h0000);
        core_u.wr(`TCP_OFS_GCTL, 8'h81);
        clr_flags(8'h27);
        wr16(`TCP_OFS_CMPA_LO, 16'h0080);
        wr16(`TCP_OFS_CNT_LO, 16'h0080);
        core_u.wr(`TCP_OFS_GCTL, 8'h00);
        // running counter lands on compare a
        wr16(`TCP_OFS_CNT_LO, 16'h0080);
        repeat (20) @(posedge i_sys_clk);
        core_u.wr(`TCP_OFS_GCTL, 8'h81);
        chk_flags("match suppressed");
        wv = {wa_pb1, wb_pa1};
        core_u.wr(`TCP_OFS_FORCE, 8'hc0);
        @(posedge i_sys_clk);
        chk("force toggles", {14'h0000, wa_pb1, wb_pa1}, {14'h0000, ~wv});
        chk("map0 idle pins", {14'h0000, wa_pa3, wb_pa5}, 16'h0000);
        core_u.rd(`TCP_OFS_FORCE, q);
        chk("force reads zero", {8'h00, q}, 16'h0000);
        chk_flags("force no flag");
        pwm_s <= 1'b1;
        core_u.wr(`TCP_OFS_FORCE, 8'hc0);
        @(posedge i_sys_clk);
        chk("force pwm ignored", {14'h0000, wa_pb1, wb_pa1}, {14'h0000, ~wv});
        pwm_s <= 1'b0;
        $display("test match done");
        for (int k = 0; k < 3; k++) begin
            core_u.wr(`TCP_OFS_GCTL, (k == 1) ? 8'h83 : 8'h81);
            core_u.wr(`TCP_OFS_CSRC, (k == 2) ? 8'h01 : 8'h00);
            chk("map select", {15'h0000, map_s}, (k == 1) ? 16'h0001 : 16'h0000);
            ext_drv <= (k == 1) ? 2'b10 : 2'b01;
            repeat (3) @(posedge i_sys_clk);
            chk("ext clock high", {15'h0000, ext_s}, 16'h0001);
            ext_drv <= (k == 1) ? 2'b01 : 2'b10;
            repeat (3) @(posedge i_sys_clk);
            chk("ext clock low", {15'h0000, ext_s}, 16'h0000);
            clr_flags(8'h27);
            lfsr = lfsr_next(lfsr);
            cv = lfsr;
            wr16(`TCP_OFS_CNT_LO, cv);
            // falling edge is the selected event
            @(posedge i_sys_clk);
            cap_drv[k] <= 1'b1;
            repeat (6) @(posedge i_sys_clk);
            cap_drv[k] <= 1'b0;
            repeat (6) @(posedge i_sys_clk);
            m_flags = 8'h20;
            chk_flags("capture flag");
            rd16(`TCP_OFS_CAP_LO, q16);
            chk("capture value", q16, cv);
        end
        $display("test capture done");
        results();
    end
endmodule : tb_top
`default_nettype wire
